/* File: core/lds_top.sv */
`timescale 1ns/1ps
module lds_top (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic reset_i,
    // Serial load pins from the host
    input wire logic ser_data_i,
    input wire logic ser_clk_i,
    input wire logic latch_i,
    // Output register
    output logic [15:0] dac_code_o,
    output logic alarm_mode_o,
    output logic [24:0] current_na_o,
    output logic out_update_o,
    // Frame status pulses
    output logic short_frame_o,
    output logic overrun_o
);

    typedef enum logic {
        LDS_IDLE = 1'b0,
        LDS_HOLD = 1'b1
    } lds_out_e;

    typedef struct packed {
        logic [lds_pkg::CODE_W-1:0] shift;
        logic [lds_pkg::CNT_W-1:0] cnt;
        logic push;
        logic [lds_pkg::WORD_W-1:0] push_word;
        lds_out_e state;
        logic [lds_pkg::HOLD_W-1:0] hold;
        logic [lds_pkg::CODE_W-1:0] code;
        logic alarm;
        logic [lds_pkg::CUR_W-1:0] cur;
        logic upd;
        logic short_f;
        logic ovr;
    } lds_top_s;

    lds_top_s st_r;
    lds_top_s st_nxt;

    logic [lds_pkg::PIN_N-1:0] pin_lvl;
    logic [lds_pkg::PIN_N-1:0] pin_rise;
    logic data_lvl;
    logic sclk_rise;
    logic latch_rise;
    logic pop;

    lds_word_if #(.W(lds_pkg::WORD_W)) wr_if ();
    lds_word_if #(.W(lds_pkg::WORD_W)) rd_if ();

    // ==========================================================
    // Pin synchronisers
    // The host pins are the whole interface; no handshake back.
    lds_pin_sync #(
        .N(lds_pkg::PIN_N)
    ) u_sync (
        .sys_clk_i(sys_clk_i),
        .reset_i(reset_i),
        .pin_i({latch_i, ser_clk_i, ser_data_i}),
        .lvl_o(pin_lvl),
        .rise_o(pin_rise)
    );

    // Data and clock share the same sync delay, so data is seen as it stood at the edge
    assign data_lvl = pin_lvl[lds_pkg::PIN_DATA];
    assign sclk_rise = pin_rise[lds_pkg::PIN_SCLK];
    assign latch_rise = pin_rise[lds_pkg::PIN_LATCH];

    // ==========================================================
    // Latched word queue
    lds_fifo #(
        .W(lds_pkg::WORD_W),
        .D(lds_pkg::FIFO_DEPTH)
    ) u_fifo (
        .sys_clk_i(sys_clk_i),
        .reset_i(reset_i),
        .wr(wr_if.snk),
        .rd(rd_if.src)
    );

    assign wr_if.valid = st_r.push;
    assign wr_if.data = st_r.push_word;
    // Drain stalls while the output is settling, so the queue can really fill
    assign rd_if.ready = (st_r.state == LDS_IDLE);
    assign pop = rd_if.valid & rd_if.ready;

    // ==========================================================
    // Next state
    always_comb begin
        st_nxt = st_r;
        st_nxt.push = 1'b0;
        st_nxt.upd = 1'b0;
        st_nxt.short_f = 1'b0;
        st_nxt.ovr = 1'b0;

        // Shift path; the word is always the last sixteen bits seen
        if (sclk_rise) begin
            st_nxt.shift = {st_r.shift[lds_pkg::CODE_W-2:0], data_lvl};
        end

        // Edge counter, saturating so long frames stay alarm frames
        if (latch_rise) begin
            st_nxt.cnt = sclk_rise ? lds_pkg::CNT_W'(1) : lds_pkg::CNT_RESET;
        end else if (sclk_rise && st_r.cnt != lds_pkg::CNT_SAT) begin
            st_nxt.cnt = st_r.cnt + lds_pkg::CNT_W'(1);
        end

        // Classify at latch
        if (latch_rise) begin
            if (st_r.cnt < lds_pkg::CNT_NORMAL) begin
                st_nxt.short_f = 1'b1;
            end else if (!wr_if.ready) begin
                // Queue full: the word is lost and flagged rather than stalling the host
                st_nxt.ovr = 1'b1;
            end else begin
                st_nxt.push = 1'b1;
                st_nxt.push_word = {(st_r.cnt > lds_pkg::CNT_NORMAL), st_r.shift};
            end
        end

        // Output register update
        unique case (st_r.state)
            LDS_IDLE: begin
                if (pop) begin
                    st_nxt.code = rd_if.data[lds_pkg::CODE_W-1:0];
                    st_nxt.alarm = rd_if.data[lds_pkg::WORD_ALARM_BIT];
                    st_nxt.cur = lds_pkg::current_na(rd_if.data[lds_pkg::WORD_ALARM_BIT],
                                                     rd_if.data[lds_pkg::CODE_W-1:0]);
                    st_nxt.upd = 1'b1;
                    st_nxt.hold = lds_pkg::OUT_HOLD_CYC - lds_pkg::HOLD_W'(1);
                    st_nxt.state = LDS_HOLD;
                end
            end
            LDS_HOLD: begin
                if (st_r.hold == lds_pkg::HOLD_ZERO) begin
                    st_nxt.state = LDS_IDLE;
                end else begin
                    st_nxt.hold = st_r.hold - lds_pkg::HOLD_W'(1);
                end
            end
        endcase
    end

    // Output register only moves on a queued latch.
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            st_r <= '{shift: '0, cnt: '0, push: 1'b0, push_word: '0, state: LDS_IDLE,
                      hold: '0, code: lds_pkg::CODE_RESET, alarm: 1'b0,
                      cur: lds_pkg::NORM_BASE_NA, upd: 1'b0, short_f: 1'b0, ovr: 1'b0};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign dac_code_o = st_r.code;
    assign alarm_mode_o = st_r.alarm;
    assign current_na_o = st_r.cur;
    assign out_update_o = st_r.upd;
    assign short_frame_o = st_r.short_f;
    assign overrun_o = st_r.ovr;

    // ==========================================================
    // Checks
    property p_shift_msb_first;
        @(posedge sys_clk_i) disable iff (reset_i)
        sclk_rise |=> (st_r.shift[0] == $past(data_lvl)) && (st_r.shift[15:1] == $past(st_r.shift[14:0]));
    endproperty
    a_shift_msb_first: assert property (p_shift_msb_first) else $error("shift not MSB first");

    property p_count_restart;
        @(posedge sys_clk_i) disable iff (reset_i)
        latch_rise && !sclk_rise |=> st_r.cnt == 5'h00;
    endproperty
    a_count_restart: assert property (p_count_restart) else $error("count not restarted");

    property p_normal_push;
        @(posedge sys_clk_i) disable iff (reset_i)
        latch_rise && st_r.cnt == 5'h10 && wr_if.ready |=> st_r.push && !st_r.push_word[16];
    endproperty
    a_normal_push: assert property (p_normal_push) else $error("normal word not queued");

    property p_alarm_push;
        @(posedge sys_clk_i) disable iff (reset_i)
        latch_rise && st_r.cnt > 5'h10 && wr_if.ready |=> st_r.push && st_r.push_word[16];
    endproperty
    a_alarm_push: assert property (p_alarm_push) else $error("alarm word not queued");

    property p_short_drop;
        @(posedge sys_clk_i) disable iff (reset_i)
        latch_rise && st_r.cnt < 5'h10 |=> !st_r.push && short_frame_o;
    endproperty
    a_short_drop: assert property (p_short_drop) else $error("short frame not dropped");

    property p_pop_update;
        @(posedge sys_clk_i) disable iff (reset_i)
        pop |=> out_update_o && dac_code_o == $past(rd_if.data[15:0]) ##1 !out_update_o;
    endproperty
    a_pop_update: assert property (p_pop_update) else $error("output not updated from queue");

    property p_hold_out;
        @(posedge sys_clk_i) disable iff (reset_i)
        !pop |=> $stable(dac_code_o) && $stable(current_na_o);
    endproperty
    a_hold_out: assert property (p_hold_out) else $error("output moved without latch");

    property p_normal_current;
        @(posedge sys_clk_i) disable iff (reset_i)
        out_update_o && !alarm_mode_o |-> current_na_o >= 25'h03d0900 && current_na_o < 25'h1312d00;
    endproperty
    a_normal_current: assert property (p_normal_current) else $error("normal current out of span");

    property p_alarm_current;
        @(posedge sys_clk_i) disable iff (reset_i)
        out_update_o && alarm_mode_o |-> current_na_o == lds_pkg::current_na(1'b1, dac_code_o)
            && current_na_o >= lds_pkg::ALRM_BASE_NA && current_na_o < 25'h16e3600;
    endproperty
    a_alarm_current: assert property (p_alarm_current) else $error("alarm current out of span");

    // ==========================================================
    // Counter, queue and pacing checks
    property p_count_sat;
        @(posedge sys_clk_i) disable iff (reset_i)
        sclk_rise && !latch_rise && st_r.cnt == lds_pkg::CNT_SAT |=> st_r.cnt == lds_pkg::CNT_SAT;
    endproperty
    a_count_sat: assert property (p_count_sat) else $error("edge count left saturation");

    property p_count_step;
        @(posedge sys_clk_i) disable iff (reset_i)
        sclk_rise && !latch_rise && st_r.cnt < lds_pkg::CNT_SAT |=> st_r.cnt == $past(st_r.cnt) + lds_pkg::CNT_W'(1);
    endproperty
    a_count_step: assert property (p_count_step) else $error("edge count did not step");

    property p_count_idle;
        @(posedge sys_clk_i) disable iff (reset_i)
        !sclk_rise && !latch_rise |=> $stable(st_r.cnt);
    endproperty
    a_count_idle: assert property (p_count_idle) else $error("edge count moved without edge");

    property p_shift_idle;
        @(posedge sys_clk_i) disable iff (reset_i)
        !sclk_rise |=> $stable(st_r.shift);
    endproperty
    a_shift_idle: assert property (p_shift_idle) else $error("shift moved without clock rise");

    property p_push_or_drop;
        @(posedge sys_clk_i) disable iff (reset_i)
        latch_rise && st_r.cnt >= lds_pkg::CNT_NORMAL |=> (overrun_o != st_r.push) && (overrun_o == !$past(wr_if.ready));
    endproperty
    a_push_or_drop: assert property (p_push_or_drop) else $error("full frame neither queued nor flagged");

    property p_push_word;
        @(posedge sys_clk_i) disable iff (reset_i)
        latch_rise && st_r.cnt >= lds_pkg::CNT_NORMAL && wr_if.ready |=> st_r.push_word[15:0] == $past(st_r.shift);
    endproperty
    a_push_word: assert property (p_push_word) else $error("queued word differs from shift");

    property p_push_ready;
        @(posedge sys_clk_i) disable iff (reset_i)
        st_r.push |-> wr_if.ready;
    endproperty
    a_push_ready: assert property (p_push_ready) else $error("push into full queue");

    property p_alarm_flag;
        @(posedge sys_clk_i) disable iff (reset_i)
        pop |=> alarm_mode_o == $past(rd_if.data[lds_pkg::WORD_ALARM_BIT]);
    endproperty
    a_alarm_flag: assert property (p_alarm_flag) else $error("alarm flag not taken from word");

    property p_normal_code;
        @(posedge sys_clk_i) disable iff (reset_i)
        pop && !rd_if.data[lds_pkg::WORD_ALARM_BIT] |=> current_na_o == lds_pkg::current_na(1'b0, dac_code_o);
    endproperty
    a_normal_code: assert property (p_normal_code) else $error("normal current not on span");

    property p_update_only_pop;
        @(posedge sys_clk_i) disable iff (reset_i)
        out_update_o |-> $past(pop);
    endproperty
    a_update_only_pop: assert property (p_update_only_pop) else $error("update without queued word");

    property p_hold_length;
        @(posedge sys_clk_i) disable iff (reset_i)
        pop |=> (!pop) [*5];
    endproperty
    a_hold_length: assert property (p_hold_length) else $error("output updated during hold");

    // Reset values are checked with reset itself as the trigger
    property p_reset_values;
        @(posedge sys_clk_i)
        reset_i |=> dac_code_o == lds_pkg::CODE_RESET && !alarm_mode_o && current_na_o == lds_pkg::NORM_BASE_NA;
    endproperty
    a_reset_values: assert property (p_reset_values) else $error("output not at reset value");

endmodule

/* File: include/lds_pkg.sv */
package lds_pkg;

    // ==========================================================
    // Word layout
    localparam int CODE_W = 16;
    localparam int WORD_W = CODE_W + 1;
    localparam int WORD_ALARM_BIT = 16;
    localparam int FIFO_DEPTH = 4;

    // ==========================================================
    // Frame classification
    localparam int CNT_W = 5;
    localparam logic [CNT_W-1:0] CNT_NORMAL = 5'h10;
    localparam logic [CNT_W-1:0] CNT_SAT = 5'h11;
    localparam logic [CNT_W-1:0] CNT_RESET = 5'h00;

    // ==========================================================
    // Pin indices inside the synchroniser
    localparam int PIN_N = 3;
    localparam int PIN_DATA = 0;
    localparam int PIN_SCLK = 1;
    localparam int PIN_LATCH = 2;

    // ==========================================================
    // Output current scaling, in nanoamps
    localparam int CUR_W = 25;
    localparam logic [CUR_W-1:0] NORM_BASE_NA = 25'h03d0900;
    localparam logic [CUR_W-1:0] NORM_SPAN_NA = 25'h0f42400;
    localparam logic [CUR_W-1:0] ALRM_BASE_NA = 25'h03567e0;
    localparam logic [CUR_W-1:0] ALRM_SPAN_NA = 25'h138ce20;
    localparam logic [CODE_W-1:0] CODE_RESET = 16'h0000;

    // ==========================================================
    // Timing
    localparam int SYS_CLK_PERIOD_NS = 40;
    localparam int OUT_HOLD_NS = 200;
    localparam int OUT_HOLD_CYC_I = (OUT_HOLD_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
    localparam int HOLD_W = 4;
    localparam logic [HOLD_W-1:0] OUT_HOLD_CYC = HOLD_W'(OUT_HOLD_CYC_I < 1 ? 1 : OUT_HOLD_CYC_I);
    localparam logic [HOLD_W-1:0] HOLD_ZERO = 4'h0;

    // ==========================================================
    // Code to loop current
    function automatic logic [CUR_W-1:0] current_na(input logic alarm, input logic [CODE_W-1:0] code);
        logic [40:0] prod;
        prod = '0;
        if (alarm) begin
            prod = 41'(ALRM_SPAN_NA) * 41'(code);
            current_na = ALRM_BASE_NA + prod[40:16];
        end else begin
            prod = 41'(NORM_SPAN_NA) * 41'(code);
            current_na = NORM_BASE_NA + prod[40:16];
        end
    endfunction

endpackage

/* File: include/lds_word_if.sv */
`timescale 1ns/1ps
interface lds_word_if #(parameter int W = 17);
    logic valid;
    logic ready;
    logic [W-1:0] data;

    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

/* File: core/lds_pin_sync.sv */
`timescale 1ns/1ps
module lds_pin_sync #(
    parameter int N = 3
) (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic reset_i,
    // Pins
    input wire logic [N-1:0] pin_i,
    // Synchronised view
    output logic [N-1:0] lvl_o,
    output logic [N-1:0] rise_o
);

    typedef struct packed {
        logic [N-1:0] s1;
        logic [N-1:0] s2;
        logic [N-1:0] prev;
    } lds_sync_s;

    lds_sync_s st_r;
    lds_sync_s st_nxt;

    // ==========================================================
    // Two flops, then the edge detector looks at the second only
    always_comb begin
        st_nxt = st_r;
        st_nxt.s1 = pin_i;
        st_nxt.s2 = st_r.s1;
        st_nxt.prev = st_r.s2;
    end

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign lvl_o = st_r.s2;
    assign rise_o = st_r.s2 & ~st_r.prev;

endmodule

/* File: core/lds_fifo.sv */
`timescale 1ns/1ps
module lds_fifo #(
    parameter int W = 17,
    parameter int D = 4
) (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic reset_i,
    // Fill and drain sides
    lds_word_if.snk wr,
    lds_word_if.src rd
);

    localparam int AW = (D > 1) ? $clog2(D) : 1;
    localparam int CW = $clog2(D + 1);

    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [CW-1:0] cnt;
    } lds_fifo_s;

    lds_fifo_s st_r;
    lds_fifo_s st_nxt;
    logic push;
    logic pop;

    function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
        ptr_inc = (p == AW'(D - 1)) ? '0 : p + AW'(1);
    endfunction

    assign wr.ready = (st_r.cnt != CW'(D));
    assign rd.valid = (st_r.cnt != '0);
    assign rd.data = st_r.mem[st_r.rp];
    assign push = wr.valid & wr.ready;
    assign pop = rd.valid & rd.ready;

    always_comb begin
        st_nxt = st_r;
        if (push) begin
            st_nxt.mem[st_r.wp] = wr.data;
            st_nxt.wp = ptr_inc(st_r.wp);
        end
        if (pop) begin
            st_nxt.rp = ptr_inc(st_r.rp);
        end
        if (push && !pop) begin
            st_nxt.cnt = st_r.cnt + CW'(1);
        end else if (pop && !push) begin
            st_nxt.cnt = st_r.cnt - CW'(1);
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

endmodule

/* File: verif/lds_host_model.sv */
`timescale 1ns/1ps
module lds_host_model (
    // Clock
    input wire logic sys_clk_i,
    // Serial load pins, all driven here
    output logic ser_data_o,
    output logic ser_clk_o,
    output logic latch_o
);
    // ==========================================================
    // Idle levels
    initial begin
        ser_data_o = 1'b0;
        ser_clk_o = 1'b0;
        latch_o = 1'b0;
    end

    // ==========================================================
    // Frame driver
    // Link clock 320 ns: four system cycles per phase, still between frames
    task automatic send(input logic [31:0] bits, input int n, input bit do_latch);
        for (int i = n - 1; i >= 0; i--) begin
            ser_data_o <= bits[i];
            repeat (4) @(posedge sys_clk_i);
            ser_clk_o <= 1'b1;
            repeat (4) @(posedge sys_clk_i);
            ser_clk_o <= 1'b0;
        end
        // Data no longer valid: show the inverse, not a stale copy
        @(posedge sys_clk_i);
        ser_data_o <= ~ser_data_o;
        if (do_latch) begin
            repeat (4) @(posedge sys_clk_i);
            latch_o <= 1'b1;
            repeat (4) @(posedge sys_clk_i);
            latch_o <= 1'b0;
        end
        repeat (4) @(posedge sys_clk_i);
    endtask
endmodule

/* File: verif/loop_dac_serial_load_test.sv */
`timescale 1ns/1ps
module loop_dac_serial_load_test;
    logic sys_clk_i;
    logic reset_i;
    logic ser_data;
    logic ser_clk;
    logic latch;
    logic [15:0] dac_code;
    logic alarm_mode;
    logic [24:0] current_na;
    logic out_update;
    logic short_frame;
    logic overrun;
    int fail_count = 0;
    int cmp_count = 0;
    int upd_cnt = 0;
    int short_cnt = 0;
    int ovr_cnt = 0;

    // ==========================================================
    // Clock, reset and instances
    initial begin
        sys_clk_i = 1'b0;
        forever #20 sys_clk_i = ~sys_clk_i;
    end

    lds_host_model i_lds_host_model (
        .sys_clk_i(sys_clk_i),
        .ser_data_o(ser_data),
        .ser_clk_o(ser_clk),
        .latch_o(latch)
    );

    lds_top i_lds_top (
        .sys_clk_i(sys_clk_i),
        .reset_i(reset_i),
        .ser_data_i(ser_data),
        .ser_clk_i(ser_clk),
        .latch_i(latch),
        .dac_code_o(dac_code),
        .alarm_mode_o(alarm_mode),
        .current_na_o(current_na),
        .out_update_o(out_update),
        .short_frame_o(short_frame),
        .overrun_o(overrun)
    );

    always @(posedge sys_clk_i) begin
        if (out_update === 1'b1) upd_cnt++;
        if (short_frame === 1'b1) short_cnt++;
        if (overrun === 1'b1) ovr_cnt++;
    end

    // ==========================================================
    // Checking helpers
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    function automatic logic [31:0] exp_cur(input bit alarm, input logic [15:0] code);
        longint base;
        longint span;
        base = alarm ? longint'(lds_pkg::ALRM_BASE_NA) : longint'(lds_pkg::NORM_BASE_NA);
        span = alarm ? longint'(lds_pkg::ALRM_SPAN_NA) : longint'(lds_pkg::NORM_SPAN_NA);
        return 32'(base + ((span * longint'(code)) >> 16));
    endfunction

    // Sends a frame, then checks outputs and pulse counts
    task automatic frame(input logic [31:0] bits, input int n, input bit lat, input int upd, input int shrt,
                         input bit alarm, input logic [15:0] code);
        int u0;
        int s0;
        int o0;
        u0 = upd_cnt;
        s0 = short_cnt;
        o0 = ovr_cnt;
        i_lds_host_model.send(bits, n, lat);
        repeat (12) @(posedge sys_clk_i);
        check("update pulses", 32'(upd), 32'(upd_cnt - u0));
        check("short pulses", 32'(shrt), 32'(short_cnt - s0));
        check("overrun pulses", 32'h0, 32'(ovr_cnt - o0));
        check("dac code", {16'h0000, code}, {16'h0000, dac_code});
        check("alarm mode", {31'h0, alarm}, {31'h0, alarm_mode});
        check("current", exp_cur(alarm, code), {7'h00, current_na});
    endtask

    // ==========================================================
    // Scenarios
    task automatic test_reset();
        check("reset code", 32'h0, {16'h0000, dac_code});
        check("reset alarm", 32'h0, {31'h0, alarm_mode});
        check("reset current", exp_cur(1'b0, 16'h0000), {7'h00, current_na});
        $display("test_reset done");
    endtask

    task automatic test_normal();
        logic [15:0] codes [3] = '{16'hffff, 16'h0000, 16'ha5c3};
        foreach (codes[i]) frame({16'h0000, codes[i]}, 16, 1'b1, 1, 0, 1'b0, codes[i]);
        $display("test_normal done");
    endtask

    task automatic test_alarm();
        frame({15'h0, 1'b1, 16'h8000}, 17, 1'b1, 1, 0, 1'b1, 16'h8000);
        frame({8'h00, 8'h5a, 16'hffff}, 24, 1'b1, 1, 0, 1'b1, 16'hffff);
        frame({16'h0000, 16'h1234}, 16, 1'b1, 1, 0, 1'b0, 16'h1234);
        $display("test_alarm done");
    endtask

    task automatic test_no_latch();
        frame({16'h0000, 16'h0f0f}, 16, 1'b0, 0, 0, 1'b0, 16'h1234);
        frame(32'h0, 0, 1'b1, 1, 0, 1'b0, 16'h0f0f);
        $display("test_no_latch done");
    endtask

    task automatic test_short();
        frame({24'h0, 8'hc3}, 8, 1'b1, 0, 1, 1'b0, 16'h0f0f);
        frame({24'h0, 8'h01}, 15, 1'b1, 0, 1, 1'b0, 16'h0f0f);
        frame({16'h0000, 16'h8001}, 16, 1'b1, 1, 0, 1'b0, 16'h8001);
        $display("test_short done");
    endtask

    // ==========================================================
    // Run control
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        reset_i = 1'b1;
        repeat (5) @(posedge sys_clk_i);
        reset_i <= 1'b0;
        repeat (4) @(posedge sys_clk_i);
        test_reset();
        test_normal();
        test_alarm();
        test_no_latch();
        test_short();
        report_and_stop();
    end

    // Whole run needs about 1560 cycles; allow about sixteen times that
    initial begin
        repeat (25000) @(posedge sys_clk_i);
        fail_count++;
        $display("[FAIL] watchdog expected finish seen hang");
        report_and_stop();
    end
endmodule
